// ===== design/lhe_lin_header_extension.sv
// Serial data buffer, serial port engine and LIN header logic behind an APB slave
// Function
// - Reading the data buffer returns the oldest receive FIFO byte.
// - Writing the data buffer pushes the byte into the transmit FIFO.
// - Ordinary serial port keeps working while LIN is enabled.
// - Master header is break, sync byte, identifier; then data and checksum.
// - Break completion raises an interrupt; software may then queue data.
// - Header detection and break transmission only while LIN enable is 1.
// - Master role bit 1 master, 0 slave; changeable only while disabled.
// - Auto-sync-update on: valid sync loads measured baud, raises auto-sync interrupt.
// - Auto-sync-update off: divisor kept, sync-received interrupt raised.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`include "lhe_regs.svh"
module lhe_lin_header_extension #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  // Input synchroniser and edge history, idle high in reset to avoid a false edge
  logic rx_m_r, rx_s_r, rx_d_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else begin
      rx_m_r <= rx_i;
      rx_s_r <= rx_m_r;
      rx_d_r <= rx_s_r;
    end
  end
  logic rx_fall;
  assign rx_fall = rx_d_r & ~rx_s_r;

  // Register and FIFO state
  lhe_pkg::lhe_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] scon_r, scon_nxt;
  logic [15:0] baud_r, baud_nxt, meas_r, meas_nxt;
  logic [4:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [7:0] transmit_fifo_r [DEPTH], transmit_fifo_nxt [DEPTH];
  logic [7:0] rfifo_r [DEPTH], rfifo_nxt [DEPTH];
  logic [AW-1:0] trd_r, trd_nxt, twr_r, twr_nxt, rrd_r, rrd_nxt, rwr_r, rwr_nxt;
  logic [AW:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;
  logic [19:0] low_r, low_nxt, scnt_r, scnt_nxt;
  logic brk_r, brk_nxt, sync_ok;
  logic [2:0] edg_r, edg_nxt;

  // Engine outputs used by the register group
  lhe_pkg::lhe_tx_st_t tx_st_r, tx_st_nxt;
  lhe_pkg::lhe_rx_st_t rx_st_r, rx_st_nxt;
  logic brk_done_r, brk_done_nxt, rx_done_r, rx_done_nxt;
  logic [7:0] rx_byte_r, rx_byte_nxt;
  logic tx_take;

  logic acc, wr, rd;
  logic [9:0] idx;
  logic [7:0] wb, head;
  logic [15:0] baud_m1;
  logic [4:0] brk_bits;
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign idx = paddr_i[11:2];
  assign wb = pwdata_i[7:0];
  assign head = rfifo_r[rrd_r];
  assign baud_m1 = (baud_r == 16'h0000) ? 16'h0000 : baud_r - 16'h0001;
  assign brk_bits = `LHE_BRK_BASE_BITS + {2'b00, ctrl_r.bl};
  assign tx_take = (tx_st_r == lhe_pkg::LHE_TX_IDLE) && (tcnt_r != '0)
    && !(ctrl_r.send_break_command && ctrl_r.en && ctrl_r.master);

  always_comb begin
    ctrl_nxt = ctrl_r;
    scon_nxt = scon_r;
    baud_nxt = baud_r;
    meas_nxt = meas_r;
    mask_nxt = mask_r;
    transmit_fifo_nxt = transmit_fifo_r;
    rfifo_nxt = rfifo_r;
    trd_nxt = trd_r;
    twr_nxt = twr_r;
    rrd_nxt = rrd_r;
    rwr_nxt = rwr_r;
    tcnt_nxt = tcnt_r;
    rcnt_nxt = rcnt_r;
    low_nxt = low_r;
    scnt_nxt = scnt_r;
    brk_nxt = brk_r;
    edg_nxt = edg_r;
    sync_ok = 1'b0;
    stat_nxt = stat_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = psel_i & ~penable_i & ~pready_o;
    if (psel_i & ~penable_i) begin
      unique case (idx)
        `LHE_IDX_DATA: prdata_nxt = {24'h000000, head};
        `LHE_IDX_CTRL: prdata_nxt = {24'h000000, ctrl_r.en, ctrl_r.master, 1'b0,
          ctrl_r.message_auto_sync_update, ctrl_r.send_break_command, ctrl_r.bl};
        `LHE_IDX_SCON: prdata_nxt = {24'h000000, scon_r};
        `LHE_IDX_BAUD: prdata_nxt = {16'h0000, baud_r};
        `LHE_IDX_SYNC: prdata_nxt = {16'h0000, meas_r};
        `LHE_IDX_STAT: prdata_nxt = {27'h0000000, stat_r};
        `LHE_IDX_MASK: prdata_nxt = {27'h0000000, mask_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (tx_take) begin
      trd_nxt = trd_r + 1'b1;
      tcnt_nxt = tcnt_nxt - 1'b1;
    end
    if (wr && idx == `LHE_IDX_DATA && tcnt_r != FULL) begin
      transmit_fifo_nxt[twr_r] = wb;
      twr_nxt = twr_r + 1'b1;
      tcnt_nxt = tcnt_nxt + 1'b1;
    end
    if (rd && idx == `LHE_IDX_DATA && rcnt_r != '0) begin
      rrd_nxt = rrd_r + 1'b1;
      rcnt_nxt = rcnt_nxt - 1'b1;
    end
    if (rx_done_r && rcnt_r != FULL) begin
      rfifo_nxt[rwr_r] = rx_byte_r;
      rwr_nxt = rwr_r + 1'b1;
      rcnt_nxt = rcnt_nxt + 1'b1;
    end
    if (wr && idx == `LHE_IDX_CTRL) begin
      ctrl_nxt.en = wb[`LHE_CTRL_EN];
      if (!ctrl_r.en) begin
        ctrl_nxt.master = wb[`LHE_CTRL_MASTER];
      end
      ctrl_nxt.auto_sync_update = wb[`LHE_CTRL_ASU];
      ctrl_nxt.message_auto_sync_update = wb[`LHE_CTRL_MESSAGE_AUTO_SYNC_UPDATE];
      ctrl_nxt.send_break_command = ctrl_r.send_break_command | wb[`LHE_CTRL_SBK];
      ctrl_nxt.bl = wb[2:0];
    end
    if (brk_done_r || !ctrl_nxt.en) begin
      ctrl_nxt.send_break_command = 1'b0;
    end
    if (wr && idx == `LHE_IDX_SCON) begin
      scon_nxt = wb;
    end
    if (wr && idx == `LHE_IDX_BAUD) begin
      baud_nxt = pwdata_i[15:0];
    end
    if (wr && idx == `LHE_IDX_MASK) begin
      mask_nxt = pwdata_i[4:0];
    end
    // Break detection and sync field timing
    low_nxt = rx_s_r ? 20'h00000 : ((low_r == 20'hfffff) ? low_r : low_r + 20'h00001);
    if (!ctrl_r.en) begin
      brk_nxt = 1'b0;
      edg_nxt = 3'h0;
      scnt_nxt = 20'h00000;
    end else begin
      if (low_r == `LHE_BRK_DETECT_BITS * {4'h0, baud_r}) begin
        brk_nxt = 1'b1;
        edg_nxt = 3'h0;
      end
      if (edg_r != 3'h0) begin
        scnt_nxt = scnt_r + 20'h00001;
      end
      if (brk_r && rx_fall) begin
        if (edg_r == 3'h0) begin
          scnt_nxt = 20'h00001;
          edg_nxt = 3'h1;
        end else if (edg_r == `LHE_SYNC_EDGES) begin
          brk_nxt = 1'b0;
          edg_nxt = 3'h0;
          sync_ok = !ctrl_r.master && scnt_r[19:3] != 17'h00000;
        end else begin
          edg_nxt = edg_r + 3'h1;
        end
      end
    end
    if (sync_ok) begin
      meas_nxt = scnt_r[18:3];
      if (ctrl_r.auto_sync_update) begin
        baud_nxt = scnt_r[18:3];
      end
    end
    stat_nxt = stat_r;
    if (wr && idx == `LHE_IDX_STAT) begin
      stat_nxt = stat_r & ~pwdata_i[4:0];
    end
    stat_nxt[`LHE_ST_RXNE] = stat_nxt[`LHE_ST_RXNE] | (rx_done_r & rcnt_r != FULL);
    stat_nxt[`LHE_ST_TXE] = stat_nxt[`LHE_ST_TXE] | (tx_take & tcnt_r == 1);
    stat_nxt[`LHE_ST_BRK] = stat_nxt[`LHE_ST_BRK] | brk_done_r;
    stat_nxt[`LHE_ST_AUTO_SYNC_INTERRUPT] = stat_nxt[`LHE_ST_AUTO_SYNC_INTERRUPT] | (sync_ok & ctrl_r.auto_sync_update);
    stat_nxt[`LHE_ST_RSI] = stat_nxt[`LHE_ST_RSI] | (sync_ok & ~ctrl_r.auto_sync_update);
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= `LHE_CTRL_RST;
      scon_r <= `LHE_SCON_RST;
      baud_r <= `LHE_BAUD_RST;
      meas_r <= 16'h0000;
      stat_r <= `LHE_STAT_RST;
      mask_r <= `LHE_MASK_RST;
      trd_r <= '0;
      twr_r <= '0;
      rrd_r <= '0;
      rwr_r <= '0;
      tcnt_r <= '0;
      rcnt_r <= '0;
      low_r <= 20'h00000;
      scnt_r <= 20'h00000;
      brk_r <= 1'b0;
      edg_r <= 3'h0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      scon_r <= scon_nxt;
      baud_r <= baud_nxt;
      meas_r <= meas_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      trd_r <= trd_nxt;
      twr_r <= twr_nxt;
      rrd_r <= rrd_nxt;
      rwr_r <= rwr_nxt;
      tcnt_r <= tcnt_nxt;
      rcnt_r <= rcnt_nxt;
      low_r <= low_nxt;
      scnt_r <= scnt_nxt;
      brk_r <= brk_nxt;
      edg_r <= edg_nxt;
      prdata_o <= prdata_nxt;
      pready_o <= pready_nxt;
      pslverr_o <= pready_nxt & pslverr_nxt;
      irq_o <= irq_nxt;
    end
    transmit_fifo_r <= transmit_fifo_nxt;
    rfifo_r <= rfifo_nxt;
  end

  // Transmit engine: data frames and LIN break with delimiter
  logic [15:0] tdiv_r, tdiv_nxt;
  logic [4:0] tbit_r, tbit_nxt;
  logic [9:0] tsh_r, tsh_nxt;
  logic tx_nxt, ttick;
  assign ttick = tdiv_r >= baud_m1;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tdiv_nxt = ttick ? 16'h0000 : tdiv_r + 16'h0001;
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    brk_done_nxt = 1'b0;
    tx_nxt = tx_o;
    unique case (tx_st_r)
      lhe_pkg::LHE_TX_IDLE: begin
        tx_nxt = 1'b1;
        tdiv_nxt = 16'h0000;
        tbit_nxt = 5'h00;
        // Send-break clears one cycle after completion; do not restart meanwhile
        if (ctrl_r.send_break_command && ctrl_r.en && ctrl_r.master && !brk_done_r) begin
          tx_st_nxt = lhe_pkg::LHE_TX_BREAK;
          tx_nxt = 1'b0;
        end else if (tx_take) begin
          tx_st_nxt = lhe_pkg::LHE_TX_DATA;
          tsh_nxt = {1'b1, transmit_fifo_r[trd_r], 1'b0};
          tx_nxt = 1'b0;
        end
      end
      lhe_pkg::LHE_TX_DATA: begin
        if (ttick) begin
          tsh_nxt = {1'b1, tsh_r[9:1]};
          tx_nxt = tsh_r[1];
          tbit_nxt = tbit_r + 5'h01;
          if (tbit_r == 5'h09) begin
            tx_st_nxt = lhe_pkg::LHE_TX_IDLE;
            tx_nxt = 1'b1;
          end
        end
      end
      lhe_pkg::LHE_TX_BREAK: begin
        tx_nxt = 1'b0;
        if (!ctrl_r.en) begin
          tx_st_nxt = lhe_pkg::LHE_TX_IDLE;
          tx_nxt = 1'b1;
        end else if (ttick) begin
          tbit_nxt = tbit_r + 5'h01;
          if (tbit_r == brk_bits - 5'h01) begin
            tx_st_nxt = lhe_pkg::LHE_TX_DELIM;
            tx_nxt = 1'b1;
          end
        end
      end
      lhe_pkg::LHE_TX_DELIM: begin
        tx_nxt = 1'b1;
        if (ttick) begin
          tx_st_nxt = lhe_pkg::LHE_TX_IDLE;
          brk_done_nxt = 1'b1;
        end
      end
      default: tx_st_nxt = lhe_pkg::LHE_TX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_st_r <= lhe_pkg::LHE_TX_IDLE;
      tdiv_r <= 16'h0000;
      tbit_r <= 5'h00;
      tsh_r <= 10'h3ff;
      brk_done_r <= 1'b0;
      tx_o <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tdiv_r <= tdiv_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      brk_done_r <= brk_done_nxt;
      tx_o <= tx_nxt;
    end
  end

  // Receive engine: start, eight data bits, stop
  logic [15:0] rdiv_r, rdiv_nxt;
  logic [3:0] rbit_r, rbit_nxt;
  logic rtick;
  assign rtick = rdiv_r >= baud_m1;
  always_comb begin
    rx_st_nxt = rx_st_r;
    rdiv_nxt = rtick ? 16'h0000 : rdiv_r + 16'h0001;
    rbit_nxt = rbit_r;
    rx_byte_nxt = rx_byte_r;
    rx_done_nxt = 1'b0;
    unique case (rx_st_r)
      lhe_pkg::LHE_RX_IDLE: begin
        rbit_nxt = 4'h0;
        if (rx_fall) begin
          rx_st_nxt = lhe_pkg::LHE_RX_START;
          rdiv_nxt = {1'b0, baud_r[15:1]};
        end
      end
      lhe_pkg::LHE_RX_START: begin
        if (rtick) begin
          rx_st_nxt = rx_s_r ? lhe_pkg::LHE_RX_IDLE : lhe_pkg::LHE_RX_DATA;
        end
      end
      lhe_pkg::LHE_RX_DATA: begin
        if (rtick) begin
          rx_byte_nxt = {rx_s_r, rx_byte_r[7:1]};
          rbit_nxt = rbit_r + 4'h1;
          if (rbit_r == 4'h7) begin
            rx_st_nxt = lhe_pkg::LHE_RX_STOP;
          end
        end
      end
      lhe_pkg::LHE_RX_STOP: begin
        if (rtick) begin
          rx_done_nxt = rx_s_r;
          rx_st_nxt = lhe_pkg::LHE_RX_IDLE;
        end
      end
      default: rx_st_nxt = lhe_pkg::LHE_RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_st_r <= lhe_pkg::LHE_RX_IDLE;
      rdiv_r <= 16'h0000;
      rbit_r <= 4'h0;
      rx_byte_r <= 8'h00;
      rx_done_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rdiv_r <= rdiv_nxt;
      rbit_r <= rbit_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_done_r <= rx_done_nxt;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_RD_HEAD: assert property (psel_i && !penable_i && !pwrite_i && idx == `LHE_IDX_DATA
    |=> prdata_o[7:0] == $past(head)) else $error("Read did not return FIFO head");
  AST_WR_PUSH: assert property (wr && idx == `LHE_IDX_DATA && !tx_take && tcnt_r < FULL
    |=> tcnt_r == $past(tcnt_r) + 1'b1) else $error("Write did not push");
  AST_RX_ON: assert property (rx_done_r && rcnt_r == '0 |=> rcnt_r == 1)
    else $error("Received byte lost");
  AST_HDR_ORDER: assert property ($fell(tx_st_r == lhe_pkg::LHE_TX_BREAK) && ctrl_r.en
    |-> tx_st_r == lhe_pkg::LHE_TX_DELIM && tx_o) else $error("Break not ended by delimiter");
  AST_BRK_IRQ: assert property (brk_done_r |=> stat_r[`LHE_ST_BRK] && !ctrl_r.send_break_command)
    else $error("Break completion not flagged");
  AST_BRK_ONCE: assert property (brk_done_r |=> tx_st_r != lhe_pkg::LHE_TX_BREAK)
    else $error("Break restarted after completion");
  AST_EN_GATE: assert property (!ctrl_r.en |=> tx_st_r != lhe_pkg::LHE_TX_BREAK && !brk_r)
    else $error("Header logic active while disabled");
  AST_ROLE_LOCK: assert property (ctrl_r.en |=> $stable(ctrl_r.master))
    else $error("Role changed while enabled");
  AST_ASU_LOAD: assert property (sync_ok && ctrl_r.auto_sync_update
    |=> baud_r == meas_r && stat_r[`LHE_ST_AUTO_SYNC_INTERRUPT]) else $error("Auto-sync update failed");
  AST_RSI_ONLY: assert property (sync_ok && !ctrl_r.auto_sync_update && !(wr && idx == `LHE_IDX_BAUD)
    |=> $stable(baud_r) && stat_r[`LHE_ST_RSI]) else $error("Sync report wrong");
  AST_BRK_LEN: assert property (tx_st_r == lhe_pkg::LHE_TX_BREAK && ttick && ctrl_r.en
    && tbit_r == brk_bits - 5'h01 |=> tx_st_r == lhe_pkg::LHE_TX_DELIM)
    else $error("Break length wrong");
endmodule

// ===== pkg/lhe_regs.svh
// Register indices, field positions, reset values and bit counts of the LIN extension
`ifndef LHE_REGS_SVH
`define LHE_REGS_SVH
`define LHE_IDX_DATA 10'h0a6
`define LHE_IDX_CTRL 10'h0a7
`define LHE_IDX_SCON 10'h0a8
`define LHE_IDX_BAUD 10'h0a9
`define LHE_IDX_SYNC 10'h0aa
`define LHE_IDX_STAT 10'h0ab
`define LHE_IDX_MASK 10'h0ac
`define LHE_CTRL_EN 7
`define LHE_CTRL_MASTER 6
`define LHE_CTRL_ASU 5
`define LHE_CTRL_MESSAGE_AUTO_SYNC_UPDATE 4
`define LHE_CTRL_SBK 3
`define LHE_ST_RXNE 0
`define LHE_ST_TXE 1
`define LHE_ST_BRK 2
`define LHE_ST_AUTO_SYNC_INTERRUPT 3
`define LHE_ST_RSI 4
`define LHE_CTRL_RST 8'h00
`define LHE_SCON_RST 8'h00
`define LHE_BAUD_RST 16'h0010
`define LHE_STAT_RST 5'h00
`define LHE_MASK_RST 5'h00
`define LHE_BRK_BASE_BITS 5'h0d
`define LHE_BRK_DETECT_BITS 20'h0000b
`define LHE_SYNC_EDGES 3'h4
`endif

// ===== pkg/lhe_pkg.sv
// Types of the LIN extension
package lhe_pkg;
  typedef enum logic [2:0] {
    LHE_TX_IDLE = 3'b000,
    LHE_TX_DATA = 3'b001,
    LHE_TX_BREAK = 3'b010,
    LHE_TX_DELIM = 3'b011
  } lhe_tx_st_t;
  typedef enum logic [1:0] {
    LHE_RX_IDLE = 2'b00,
    LHE_RX_START = 2'b01,
    LHE_RX_DATA = 2'b10,
    LHE_RX_STOP = 2'b11
  } lhe_rx_st_t;
  typedef struct packed {
    logic en;
    logic master;
    logic auto_sync_update;
    logic message_auto_sync_update;
    logic send_break_command;
    logic [2:0] bl;
  } lhe_ctrl_t;
endpackage

// ===== test/lhe_lin_node.sv
// Behavioural LIN node that puts an optional break and one byte on the shared wire
`timescale 1ns/100ps
module lhe_lin_node (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic brk_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] bit_clks_i,
  output logic line_o,
  output logic busy_o
);
  logic [9:0] frame;
  int n;
  task automatic hold_bit(input logic lvl);
    line_o <= lvl;
    repeat (bit_clks_i) @(posedge clk_i);
  endtask
  // Recessive between frames, where the bus pull-up leaves the wire
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        frame = {1'b1, byte_i, 1'b0};
        if (brk_i) begin
          for (n = 0; n < 13; n++) hold_bit(1'b0);
          hold_bit(1'b1);
        end
        for (n = 0; n < 10; n++) hold_bit(frame[n]);
        line_o <= 1'b1;
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// ===== test/test_lin_header_extension.sv
// Self-checking bench: registers, loopback, master break and slave sync
`timescale 1ns/100ps
`include "lhe_regs.svh"
module test_lin_header_extension;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, tx, irq, line, busy, go, brk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] nbyte;
  logic [15:0] nbits;
  wire rx = tx & line;
  int fails = 0;
  int total_checks = 0;
  int run = 0;
  int max_low = 0;
  logic low_clr = 1'b0;
  always #25 clk_i = ~clk_i;
  lhe_lin_header_extension #(.DEPTH(4)) dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx), .tx_o(tx),
    .irq_o(irq));
  lhe_lin_node node (.clk_i(clk_i), .go_i(go), .brk_i(brk), .byte_i(nbyte),
    .bit_clks_i(nbits), .line_o(line), .busy_o(busy));
  // Longest dominant run seen on the transmit pin
  always @(posedge clk_i) begin
    run <= (tx === 1'b1) ? 0 : run + 1;
    if (low_clr) max_low <= 0;
    else if (tx !== 1'b1 && run + 1 > max_low) max_low <= run + 1;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_stat(input int b);
    int k;
    for (k = 0; k < 500; k++) begin
      apb(1'b0, `LHE_IDX_STAT, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    if (k == 500) begin
      fails++;
      conclude();
    end
  endtask
  task automatic node_send(input logic [15:0] p);
    int k;
    brk <= 1'b1;
    nbyte <= 8'h55;
    nbits <= p;
    go <= 1'b1;
    for (k = 0; k < 9000 && busy !== 1'b1; k++) @(posedge clk_i);
    go <= 1'b0;
    if (busy !== 1'b1) begin
      fails++;
      conclude();
    end
    for (k = 0; k < 9000 && busy !== 1'b0; k++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      fails++;
      conclude();
    end
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    go = 1'b0;
    brk = 1'b0;
    nbyte = 8'h00;
    nbits = 16'h0010;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, `LHE_IDX_CTRL, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    apb(1'b0, `LHE_IDX_BAUD, 32'h0);
    check("baud_reset", rd, 32'h10);
    apb(1'b0, 10'h0b0, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    apb(1'b1, `LHE_IDX_SCON, 32'hb0);
    apb(1'b0, `LHE_IDX_SCON, 32'h0);
    check("scon", rd, 32'hb0);
    // Loopback byte through the wired-AND bus, with the receive interrupt
    apb(1'b1, `LHE_IDX_MASK, 32'h1);
    apb(1'b1, `LHE_IDX_DATA, 32'ha5);
    wait_stat(0);
    check("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b1, `LHE_IDX_STAT, 32'h1);
    apb(1'b0, `LHE_IDX_DATA, 32'h0);
    check("rx_byte", rd, 32'ha5);
    check("irq_clear", {31'h0, irq}, 32'h0);
    // Master header with break length 2
    apb(1'b1, `LHE_IDX_CTRL, 32'h42);
    apb(1'b1, `LHE_IDX_CTRL, 32'hc2);
    check("tx_idle", {31'h0, tx}, 32'h1);
    low_clr <= 1'b1;
    @(posedge clk_i);
    low_clr <= 1'b0;
    apb(1'b1, `LHE_IDX_CTRL, 32'hca);
    apb(1'b1, `LHE_IDX_DATA, 32'h55);
    apb(1'b1, `LHE_IDX_DATA, 32'h12);
    wait_stat(2);
    check("break_len", (max_low >= 240 && max_low <= 242) ? 32'h1 : 32'h0, 32'h1);
    apb(1'b0, `LHE_IDX_CTRL, 32'h0);
    check("sbk_clear", rd, 32'hc2);
    wait_stat(0);
    apb(1'b1, `LHE_IDX_STAT, 32'h1);
    wait_stat(0);
    apb(1'b0, `LHE_IDX_DATA, 32'h0);
    check("sync_byte", rd, 32'h55);
    apb(1'b0, `LHE_IDX_DATA, 32'h0);
    check("pid_byte", rd, 32'h12);
    // Role change refused while enabled
    apb(1'b1, `LHE_IDX_CTRL, 32'h82);
    apb(1'b0, `LHE_IDX_CTRL, 32'h0);
    check("role_locked", rd, 32'hc2);
    apb(1'b1, `LHE_IDX_CTRL, 32'h02);
    apb(1'b0, `LHE_IDX_CTRL, 32'h0);
    check("role_kept", rd, 32'h42);
    low_clr <= 1'b1;
    @(posedge clk_i);
    low_clr <= 1'b0;
    apb(1'b1, `LHE_IDX_CTRL, 32'h7a);
    repeat (400) @(posedge clk_i);
    check("no_break_off", max_low, 32'h0);
    apb(1'b0, `LHE_IDX_CTRL, 32'h0);
    check("ctrl_fields", rd, 32'h52);
    // Slave sync measurement, with and without auto update
    apb(1'b1, `LHE_IDX_CTRL, 32'h00);
    apb(1'b1, `LHE_IDX_STAT, 32'h1f);
    apb(1'b1, `LHE_IDX_MASK, 32'h08);
    apb(1'b1, `LHE_IDX_CTRL, 32'ha0);
    node_send(16'h0014);
    wait_stat(3);
    check("asu_irq", {31'h0, irq}, 32'h1);
    apb(1'b0, `LHE_IDX_BAUD, 32'h0);
    check("baud_loaded", rd, 32'h14);
    apb(1'b1, `LHE_IDX_CTRL, 32'h80);
    apb(1'b1, `LHE_IDX_STAT, 32'h1f);
    node_send(16'h0018);
    wait_stat(4);
    check("asu_quiet", {31'h0, rd[3]}, 32'h0);
    apb(1'b0, `LHE_IDX_BAUD, 32'h0);
    check("baud_kept", rd, 32'h14);
    apb(1'b0, `LHE_IDX_SYNC, 32'h0);
    check("sync_measured", rd, 32'h18);
    conclude();
  end
endmodule
